// *** pkg/vrc_pkg.sv ***
// Purpose: Constants shared by the voltage ramp control register bank.
// Assumes: 250 MHz system clock, 8-bit register subaddresses.
// Notes:   Times are kept in their own units; cycle counts derive from them.
package vrc_pkg;
    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0] VRC_ADDR_RAMP = 8'h1A;  // Ramp rate control
    localparam logic [7:0] VRC_ADDR_LDO = 8'h1B;   // Linear regulator code
    localparam logic [7:0] VRC_RAMP_RESET = 8'h06; // Ramp reset value
    localparam logic [5:0] VRC_LDO_RESET = 6'h3D;  // Linear reset code
    localparam logic [7:0] VRC_ZERO = 8'h00;       // Unmapped read value

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int VRC_TRIG_BIT = 7;               // Transition trigger
    localparam int VRC_BYP_BIT = 6;                // Trigger bypass
    localparam int VRC_RATE_MSB = 2;               // Rate field top bit
    localparam int VRC_LDO_MSB = 5;                // Linear code top bit
    localparam int VRC_CODE_W = 6;                 // Set-point code width
    localparam logic [2:0] VRC_RATE_IMMED = 3'h7;  // No stepping delay
    localparam logic [2:0] VRC_RATE_SLOWEST = 3'h6; // Shift reference

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int VRC_CLK_PERIOD_PS = 4000;       // 250 MHz clock
    localparam int VRC_DWELL_UNIT_PS = 2500000;    // 2.5 us per step
    localparam int VRC_DWELL_UNIT_CYC = VRC_DWELL_UNIT_PS / VRC_CLK_PERIOD_PS;
    localparam int VRC_BLANK_MS = 5;               // Monitor blanking
    localparam int VRC_PS_PER_MS = 1000000000;
    localparam int VRC_BLANK_CYC =
        (VRC_BLANK_MS * (VRC_PS_PER_MS / VRC_CLK_PERIOD_PS));
endpackage : vrc_pkg

// *** hdl/vrc_timer.sv ***
// Purpose: One-shot down counter used for step dwell and monitor blanking.
// Assumes: load_cnt is at least one.
// Notes:   busy_r stands for load_cnt cycles; tick_r pulses at the end.
`timescale 1ns/1ps
module vrc_timer #(
    parameter int CNT_W = 16
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Control
    input wire logic load,
    input wire logic [CNT_W-1:0] load_cnt,
    // Status
    output logic busy_r,
    output logic tick_r
);
    // ----------------------------------------------------------------
    // Counter
    // ----------------------------------------------------------------
    logic [CNT_W-1:0] cnt_r; // Cycles left minus one
    wire logic at_end = busy_r && (cnt_r == '0);

    // Load restarts the count; otherwise count down every cycle, idle or busy, holding only at the end
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt_r <= '0;
            busy_r <= 1'b0;
            tick_r <= 1'b0;
        end else if (load) begin
            cnt_r <= load_cnt - 1'b1;
            busy_r <= 1'b1;
            tick_r <= 1'b0;
        end else begin
            cnt_r <= at_end ? cnt_r : cnt_r - 1'b1;
            busy_r <= busy_r && !at_end;
            tick_r <= at_end;
        end
    end
endmodule : vrc_timer

// *** hdl/vrc_ramp_ctrl.sv ***
// Purpose: Ramp rate control and linear regulator code registers.
// Assumes: Register port and set-point inputs are on clk_sys.
// Notes:   Present buck codes move one code per dwell toward the targets; at rate 7 they jump to them in one step.
`timescale 1ns/1ps
module vrc_ramp_ctrl
    import vrc_pkg::*;
#(
    parameter int DWELL_UNIT = vrc_pkg::VRC_DWELL_UNIT_CYC,
    parameter int BLANK_CYC = vrc_pkg::VRC_BLANK_CYC,
    parameter logic [vrc_pkg::VRC_CODE_W-1:0] BUCK_RESET_CODE = '0
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata_r,
    // Password state
    input wire logic unlock_ok,
    // Stored buck set-points and their update strobes
    input wire logic [vrc_pkg::VRC_CODE_W-1:0] core_buck_one_sp,
    input wire logic [vrc_pkg::VRC_CODE_W-1:0] core_buck_two_sp,
    input wire logic core_buck_one_upd,
    input wire logic core_buck_two_upd,
    // Regulator outputs
    output logic [vrc_pkg::VRC_CODE_W-1:0] core_buck_one_code_r,
    output logic [vrc_pkg::VRC_CODE_W-1:0] core_buck_two_code_r,
    output logic ramp_busy_r,
    output logic [vrc_pkg::VRC_CODE_W-1:0] linear_reg_code_r,
    output logic monitor_blank_r,
    output logic ldo_wr_reject_r
);
    import vrc_pkg::*;

    localparam int DWELL_W = 24; // Holds 64 dwell units
    localparam int BLANK_W = 24; // Holds the blanking count

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // One code toward the target, or hold when equal
    function automatic logic [VRC_CODE_W-1:0] step_toward(
        input logic [VRC_CODE_W-1:0] cur,
        input logic [VRC_CODE_W-1:0] tgt
    );
        if (cur < tgt) begin
            step_toward = cur + 1'b1;
        end else if (cur > tgt) begin
            step_toward = cur - 1'b1;
        end else begin
            step_toward = cur;
        end
    endfunction : step_toward

    // Dwell per step: unit doubled for each code below the fastest
    function automatic logic [DWELL_W-1:0] dwell_of(input logic [2:0] rate);
        logic [2:0] sh;
        sh = VRC_RATE_SLOWEST - rate;
        dwell_of = DWELL_W'(DWELL_UNIT) << sh;
    endfunction : dwell_of

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic trig_r;                       // Transition trigger bit
    logic bypass_r;                     // Trigger bypass bit
    logic [2:0] rate_r;                 // Ramp rate code
    logic [VRC_CODE_W-1:0] tgt_one_r;   // Latched target, buck one
    logic [VRC_CODE_W-1:0] tgt_two_r;   // Latched target, buck two
    logic dwell_tick;                   // End of one dwell
    logic blank_busy;                   // Blanking timer running

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    wire logic wr_ramp = reg_wr && (reg_addr == VRC_ADDR_RAMP);
    wire logic wr_ldo = reg_wr && (reg_addr == VRC_ADDR_LDO);
    wire logic go_wr = wr_ramp && reg_wdata[VRC_TRIG_BIT];
    wire logic ldo_ok = wr_ldo && unlock_ok;
    wire logic sp_upd = core_buck_one_upd || core_buck_two_upd;
    wire logic byp_start = bypass_r && sp_upd;
    wire logic start = go_wr || byp_start;
    wire logic immed = (rate_r == VRC_RATE_IMMED);
    wire logic at_tgt = (core_buck_one_code_r == tgt_one_r) &&
                        (core_buck_two_code_r == tgt_two_r);
    wire logic done = ramp_busy_r && at_tgt && !start;
    wire logic do_step = ramp_busy_r && !start && (immed || dwell_tick);
    wire logic dwell_load = start || (do_step && !immed);
    // A trigger write that also sets the rate must dwell at the new rate
    wire logic [2:0] rate_now = wr_ramp ? reg_wdata[VRC_RATE_MSB:0] : rate_r;
    wire logic [DWELL_W-1:0] dwell_cnt = dwell_of(rate_now);
    wire logic [7:0] ramp_view = {trig_r, bypass_r, 3'b000, rate_r};
    wire logic [7:0] ldo_view = {2'b00, linear_reg_code_r};
    wire logic [7:0] rd_mux = (reg_addr == VRC_ADDR_RAMP) ? ramp_view :
                              (reg_addr == VRC_ADDR_LDO) ? ldo_view :
                              VRC_ZERO;

    // ----------------------------------------------------------------
    // Ramp rate control register
    // ----------------------------------------------------------------
    // Trigger set by write of one, cleared at completion; set wins
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            trig_r <= VRC_RAMP_RESET[VRC_TRIG_BIT];
            bypass_r <= VRC_RAMP_RESET[VRC_BYP_BIT];
            rate_r <= VRC_RAMP_RESET[VRC_RATE_MSB:0];
        end else begin
            trig_r <= go_wr || (trig_r && !done);
            bypass_r <= wr_ramp ? reg_wdata[VRC_BYP_BIT] : bypass_r;
            rate_r <= wr_ramp ? reg_wdata[VRC_RATE_MSB:0] : rate_r;
        end
    end

    // ----------------------------------------------------------------
    // Buck stepping (only the two core bucks are rate limited)
    // ----------------------------------------------------------------
    // Latch targets at start, step each dwell (jump at rate 7), finish when both match
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            tgt_one_r <= BUCK_RESET_CODE;
            tgt_two_r <= BUCK_RESET_CODE;
            core_buck_one_code_r <= BUCK_RESET_CODE;
            core_buck_two_code_r <= BUCK_RESET_CODE;
            ramp_busy_r <= 1'b0;
        end else begin
            if (start) begin
                tgt_one_r <= core_buck_one_sp;
                tgt_two_r <= core_buck_two_sp;
            end
            if (do_step && immed) begin
                core_buck_one_code_r <= tgt_one_r;
                core_buck_two_code_r <= tgt_two_r;
            end else if (do_step) begin
                core_buck_one_code_r <=
                    step_toward(core_buck_one_code_r, tgt_one_r);
                core_buck_two_code_r <=
                    step_toward(core_buck_two_code_r, tgt_two_r);
            end
            ramp_busy_r <= start || (ramp_busy_r && !done);
        end
    end

    // Dwell timer between code steps
    vrc_timer #(
        .CNT_W(DWELL_W)
    ) u_dwell (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .load(dwell_load),
        .load_cnt(dwell_cnt),
        .busy_r(),
        .tick_r(dwell_tick)
    );

    // ----------------------------------------------------------------
    // Linear regulator code register
    // ----------------------------------------------------------------
    // Accept only unlocked writes; flag refused ones for one cycle
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            linear_reg_code_r <= VRC_LDO_RESET;
            ldo_wr_reject_r <= 1'b0;
        end else begin
            // Full six-bit range is passed on unchanged
            linear_reg_code_r <= ldo_ok ?
                reg_wdata[VRC_LDO_MSB:0] : linear_reg_code_r;
            ldo_wr_reject_r <= wr_ldo && !unlock_ok;
        end
    end

    // Monitor blanking after each accepted write
    vrc_timer #(
        .CNT_W(BLANK_W)
    ) u_blank (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .load(ldo_ok),
        .load_cnt(BLANK_W'(BLANK_CYC)),
        .busy_r(blank_busy),
        .tick_r()
    );

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    // Blank flag follows the timer; read data registered
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            monitor_blank_r <= 1'b0;
            reg_rdata_r <= VRC_ZERO;
        end else begin
            monitor_blank_r <= blank_busy || ldo_ok;
            reg_rdata_r <= reg_rd ? rd_mux : reg_rdata_r;
        end
    end
endmodule : vrc_ramp_ctrl

// *** dv/vrc_ramp_ctrl_props.sv ***
// Purpose: Port assertions for the ramp control register bank.
// Assumes: One clock domain, async active-low reset.
// Notes:   Bound to every vrc_ramp_ctrl instance.
`timescale 1ns/1ps
module vrc_chk
    import vrc_pkg::*;
#(parameter int DWELL_UNIT = 4, parameter int BLANK_CYC = 50) (
    // Clock, reset and register port
    input wire logic clk_sys, input wire logic rst_n,
    input wire logic reg_wr, input wire logic reg_rd,
    input wire logic [7:0] reg_addr, input wire logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata_r, input wire logic unlock_ok,
    // Set-point side
    input wire logic [5:0] core_buck_one_sp,
    input wire logic [5:0] core_buck_two_sp,
    input wire logic core_buck_one_upd, input wire logic core_buck_two_upd,
    // Regulator outputs
    input wire logic [5:0] core_buck_one_code_r,
    input wire logic [5:0] core_buck_two_code_r,
    input wire logic ramp_busy_r, input wire logic [5:0] linear_reg_code_r,
    input wire logic monitor_blank_r, input wire logic ldo_wr_reject_r
);
    // ------------------------------------------------------------
    // Decodes and properties
    // ------------------------------------------------------------
    wire ldo_a = reg_addr == VRC_ADDR_LDO;  // Linear code address
    wire ramp_a = reg_addr == VRC_ADDR_RAMP; // Ramp control address
    wire quiet = !ramp_busy_r && !reg_wr && !core_buck_one_upd
                 && !core_buck_two_upd;      // Nothing can start a ramp
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    property p_rej;
        reg_wr && ldo_a && !unlock_ok |=>
            ldo_wr_reject_r && $stable(linear_reg_code_r);
    endproperty
    a_rej: assert property (p_rej) else $error("locked write taken");
    property p_ldo;
        reg_wr && ldo_a && unlock_ok |=>
            {2'h0, linear_reg_code_r} == ($past(reg_wdata) & 8'h3F);
    endproperty
    a_ldo: assert property (p_ldo) else $error("linear code bad");
    property p_blank;
        reg_wr && ldo_a && unlock_ok |=> monitor_blank_r [*8];
    endproperty
    a_blank: assert property (p_blank) else $error("no blanking");
    property p_go;
        reg_wr && ramp_a && reg_wdata[VRC_TRIG_BIT] |=> ramp_busy_r;
    endproperty
    a_go: assert property (p_go) else $error("trigger ignored");
    property p_hold;
        quiet |=> $stable(core_buck_one_code_r)
                  && $stable(core_buck_two_code_r);
    endproperty
    a_hold: assert property (p_hold) else $error("code moved idle");
    property p_rsv_ramp;
        reg_rd && ramp_a |=> reg_rdata_r[5:3] == 3'h0;
    endproperty
    a_rsv_ramp: assert property (p_rsv_ramp) else $error("rsv set");
    property p_rd_ldo;
        reg_rd && !reg_wr && ldo_a |=>
            reg_rdata_r == {2'h0, $past(linear_reg_code_r)};
    endproperty
    a_rd_ldo: assert property (p_rd_ldo) else $error("ldo read bad");
    property p_unmap;
        reg_rd && !ldo_a && !ramp_a |=> reg_rdata_r == VRC_ZERO;
    endproperty
    a_unmap: assert property (p_unmap) else $error("unmapped data");
endmodule : vrc_chk
bind vrc_ramp_ctrl vrc_chk #(.DWELL_UNIT(DWELL_UNIT), .BLANK_CYC(BLANK_CYC))
    chk_u (.clk_sys(clk_sys), .rst_n(rst_n), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata_r(reg_rdata_r), .unlock_ok(unlock_ok),
    .core_buck_one_sp(core_buck_one_sp), .core_buck_two_sp(core_buck_two_sp),
    .core_buck_one_upd(core_buck_one_upd),
    .core_buck_two_upd(core_buck_two_upd),
    .core_buck_one_code_r(core_buck_one_code_r),
    .core_buck_two_code_r(core_buck_two_code_r),
    .ramp_busy_r(ramp_busy_r), .linear_reg_code_r(linear_reg_code_r),
    .monitor_blank_r(monitor_blank_r), .ldo_wr_reject_r(ldo_wr_reject_r));

// *** dv/vrc_ramp_ctrl_tb.sv ***
// Purpose: Self-checking bench for the ramp control register bank.
// Assumes: Shortened dwell and blanking parameters.
// Notes:   Inputs change 1 ns after the rising edge.
`timescale 1ns/1ps
module vrc_ramp_ctrl_tb;
    import vrc_pkg::*;
    // ------------------------------------------------------------
    // Stimulus and checks
    // ------------------------------------------------------------
    localparam int DW = 4;  // Dwell unit in cycles
    localparam int BC = 50; // Blanking in cycles
    logic clk_sys = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, unlock_ok = 0;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, rdata;
    logic [5:0] sp1 = 6'h00, sp2 = 6'h00, code1, code2, ldo;
    logic upd1 = 0, upd2 = 0, busy, blank, rej;
    int err_count = 0, n_tests = 0, n;
    always #2 clk_sys = ~clk_sys;
    vrc_ramp_ctrl #(.DWELL_UNIT(DW), .BLANK_CYC(BC)) dut_u (
        .clk_sys(clk_sys), .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_r(rdata),
        .unlock_ok(unlock_ok), .core_buck_one_sp(sp1),
        .core_buck_two_sp(sp2), .core_buck_one_upd(upd1),
        .core_buck_two_upd(upd2), .core_buck_one_code_r(code1),
        .core_buck_two_code_r(code2), .ramp_busy_r(busy),
        .linear_reg_code_r(ldo), .monitor_blank_r(blank),
        .ldo_wr_reject_r(rej));
    // Compare and count
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    // One write strobe
    task wr(input logic [7:0] a, input logic [7:0] d);
        reg_wr = 1;
        reg_addr = a;
        reg_wdata = d;
        @(posedge clk_sys);
        #1 reg_wr = 0;
    endtask : wr
    // One read strobe, data checked after the edge
    task rd_chk(input logic [7:0] a, input logic [7:0] exp);
        reg_rd = 1;
        reg_addr = a;
        @(posedge clk_sys);
        #1 reg_rd = 0;
        chk(rdata, exp);
        // Idle edge so a following read raises its strobe afresh
        @(posedge clk_sys);
        #1;
    endtask : rd_chk
    // Count cycles until the ramp ends
    task wait_idle;
        n = 0;
        while (busy !== 1'b0 && n < 3000) begin
            @(posedge clk_sys);
            #1 n++;
        end
    endtask : wait_idle
    // Triggered ramp of both bucks at rate r to code c
    task ramp(input logic [2:0] r, input logic [5:0] c);
        int steps;
        int dw;
        logic in_win;
        steps = (c > code1) ? c - code1 : code1 - c;
        dw = (r == VRC_RATE_IMMED) ? 0 : DW << (6 - r);
        sp1 = c;
        sp2 = c;
        wr(VRC_ADDR_RAMP, {5'h10, r});
        chk(8'(busy), 8'h01);
        wait_idle;
        chk({2'h0, code1}, {2'h0, c});
        chk({2'h0, code2}, {2'h0, c});
        in_win = n >= steps * dw && n <= steps * (dw + 1) + 4;
        chk(8'(in_win), 8'h01);
    endtask : ramp
    // Verdict and end of run
    task final_report;
        if (err_count == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : final_report
    // Watchdog against a hang
    initial begin
        #200000;
        err_count++;
        final_report;
    end
    // Main sequence
    initial begin
        repeat (3) @(posedge clk_sys);
        #1 rst_n = 1;
        rd_chk(VRC_ADDR_RAMP, VRC_RAMP_RESET);
        rd_chk(VRC_ADDR_LDO, 8'h3D);
        rd_chk(8'h1C, VRC_ZERO);
        wr(VRC_ADDR_RAMP, 8'h3F);
        rd_chk(VRC_ADDR_RAMP, 8'h07);
        // Lowering ramps take pulse skipping as already off upstream
        for (int r = 0; r < 8; r++) ramp(3'(r), (r % 2) ? 6'h02 : 6'h05);
        rd_chk(VRC_ADDR_RAMP, 8'h07);
        sp1 = 6'h20;
        sp2 = 6'h20;
        wr(VRC_ADDR_RAMP, 8'h07);
        repeat (10) @(posedge clk_sys);
        #1 chk({2'h0, code1}, 8'h02);
        wr(VRC_ADDR_RAMP, 8'h47);
        upd1 = 1;
        @(posedge clk_sys);
        #1 upd1 = 0;
        wait_idle;
        chk({2'h0, code2}, 8'h20);
        wr(VRC_ADDR_LDO, 8'h15);
        chk(8'(rej), 8'h01);
        chk(8'(blank), 8'h00);
        chk({2'h0, ldo}, 8'h3D);
        rd_chk(VRC_ADDR_LDO, 8'h3D);
        unlock_ok = 1;
        wr(VRC_ADDR_LDO, 8'hC5);
        chk({2'h0, ldo}, 8'h05);
        n = 0;
        while (blank === 1'b1 && n < 200) begin
            @(posedge clk_sys);
            #1 n++;
        end
        chk(8'(n >= BC - 1 && n <= BC + 2), 8'h01);
        rd_chk(VRC_ADDR_LDO, 8'h05);
        wr(VRC_ADDR_LDO, 8'h3F);
        rd_chk(VRC_ADDR_LDO, 8'h3F);
        final_report;
    end
endmodule : vrc_ramp_ctrl_tb
